// [common/eeprom_pkg.sv]
// Shared constants, types and helpers for the serial EEPROM command port
package eeprom_pkg;
  typedef enum logic [2:0] {
    V1K = 3'h0, V2K7 = 3'h1, V2K8 = 3'h2, V4K = 3'h3, V16K = 3'h4
  } variant_type;
  typedef enum logic [2:0] {
    K_READ = 3'h0, K_WRITE = 3'h1, K_ERASE = 3'h2, K_UNLOCK = 3'h3,
    K_LOCK = 3'h4, K_ERASE_ALL = 3'h5, K_FILL_ALL = 3'h6
  } kind_type;
  typedef enum logic [3:0] {
    L_IDLE = 4'h1, L_SHIFT = 4'h2, L_READ = 4'h4, L_DONE = 4'h8
  } link_state_type;
  localparam logic [1:0] OP_EXT = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_ERASE = 2'h3;
  localparam logic [1:0] EXT_LOCK = 2'h0;
  localparam logic [1:0] EXT_FILL = 2'h1;
  localparam logic [1:0] EXT_ERASE_ALL = 2'h2;
  localparam logic [1:0] EXT_UNLOCK = 2'h3;
  localparam int ADDR_W = 11;
  localparam int DATA_W = 16;
  localparam int SHIFT_W = 29;
  localparam int CNT_W = 5;
  localparam int MEM_BYTES = 2048;
  localparam logic [CNT_W-1:0] OPCODE_BITS = 5'h02;
  localparam logic [CNT_W-1:0] DATA_BITS_WIDE = 5'h10;
  localparam logic [CNT_W-1:0] DATA_BITS_NARROW = 5'h08;
  localparam logic [CNT_W-1:0] ABITS_1K = 5'h06;
  localparam logic [CNT_W-1:0] ABITS_2K7 = 5'h07;
  localparam logic [CNT_W-1:0] ABITS_2K8 = 5'h08;
  localparam logic [CNT_W-1:0] ABITS_4K = 5'h08;
  localparam logic [CNT_W-1:0] ABITS_16K = 5'h0A;
  localparam logic [3:0] CAP_1K = 4'h7;
  localparam logic [3:0] CAP_2K = 4'h8;
  localparam logic [3:0] CAP_4K = 4'h9;
  localparam logic [3:0] CAP_16K = 4'hB;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam int PROG_TIME_MS = 5;
  localparam int CLK_FREQ_KHZ = 10000;
  localparam int PROG_CYCLES = PROG_TIME_MS * CLK_FREQ_KHZ;
  typedef struct packed {
    kind_type kind;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } command_type;

  function automatic logic [CNT_W-1:0] addr_bits(input variant_type v, input logic wide);
    logic [CNT_W-1:0] b;
    case (v)
      V1K: b = ABITS_1K;
      V2K7: b = ABITS_2K7;
      V2K8: b = ABITS_2K8;
      V4K: b = ABITS_4K;
      default: b = ABITS_16K;
    endcase
    return wide ? b : b + 5'h01;
  endfunction

  function automatic logic [3:0] cap_bits(input variant_type v);
    case (v)
      V1K: return CAP_1K;
      V2K7, V2K8: return CAP_2K;
      V4K: return CAP_4K;
      default: return CAP_16K;
    endcase
  endfunction

  function automatic kind_type decode_kind(input logic [1:0] op, input logic [1:0] ext);
    case (op)
      OP_READ: return K_READ;
      OP_WRITE: return K_WRITE;
      OP_ERASE: return K_ERASE;
      default: begin
        case (ext)
          EXT_UNLOCK: return K_UNLOCK;
          EXT_LOCK: return K_LOCK;
          EXT_ERASE_ALL: return K_ERASE_ALL;
          default: return K_FILL_ALL;
        endcase
      end
    endcase
  endfunction
endpackage

// [core/sync2.sv]
// Two-flop synchroniser for a bundle of level signals
`timescale 1ns/1ps
module sync2 #(parameter int WIDTH = 1) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] sync_next;

  always_comb begin
    meta_next = async_in;
    sync_next = meta_reg;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_out = sync_reg;
endmodule // sync2

// [core/serial_eeprom_command_port.sv]
// Serial EEPROM command front end: link decoder, read shifter, self-timed store
//
// Overview of operation
// - Wide words: frames of 9, 10, 11, 11 or 13 bits per variant.
// - Byte words: each frame one address bit longer, 10 to 14 bits.
// - Frame is start one, opcode, address, then data for write-type commands.
// - Address is 6, 7, 8 or 10 bits, plus one in byte mode.
// - Every input bit is captured on the serial clock rising edge.
// - Output stays high impedance except during read data or status.
// - Status output low while the program cycle runs, high when ready.
// - A dummy one shifted in releases the status output.
// - Output release happens on a serial clock falling edge.
// - 16K part: write and erase commands need the program enable pin high.
// - 16K part: floating enable means enabled (the pin has no pull-up here, so a floating pin refuses stores); unlock and lock ignore it.
// - 16K part: each program or erase cycle ends within 5 ms.
// - Read sends a zero bit then the word MSB first on rising edges.
// - Continued clocking reads successive words with wrap, except 1K part.
// - Writes locked at power-up until unlock; reads always allowed.
// - Deselect after a store command launches the cycle; erased bits read one.
`timescale 1ns/1ps
module serial_eeprom_command_port #(
  parameter eeprom_pkg::variant_type VARIANT = eeprom_pkg::V16K,
  parameter int PROG_CYCLES = eeprom_pkg::PROG_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic chip_select,
  input wire logic serial_clock_in,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_out_oe_n,
  input wire logic word_width_select,
  input wire logic program_enable_pin,
  output logic busy,
  output logic write_unlocked
);
  localparam int CYC_W = $clog2(PROG_CYCLES + 1);
  localparam logic [CYC_W-1:0] CYC_LAST = CYC_W'(PROG_CYCLES - 1);

  // Contents are nonvolatile and deliberately carry no reset
  logic [7:0] mem [0:eeprom_pkg::MEM_BYTES-1];

  logic cs_s, done_s, wide_s, pe_s;
  logic [3:0] sync_vec;
  logic frame_done;
  eeprom_pkg::command_type cmd_reg, cmd_next;

  sync2 #(.WIDTH(4)) u_sync (
    .clk(clk),
    .rst(rst),
    .async_in({chip_select, frame_done, word_width_select, program_enable_pin}),
    .sync_out(sync_vec)
  );
  assign {cs_s, done_s, wide_s, pe_s} = sync_vec;

  // Sizing decoded from the strapped organisation, held static during use
  logic [eeprom_pkg::CNT_W-1:0] abits, dbits, hdr_len;
  logic [eeprom_pkg::ADDR_W-1:0] amask, cap_mask, wmask;
  logic [eeprom_pkg::DATA_W-1:0] dmask;
  always_comb begin
    abits = eeprom_pkg::addr_bits(VARIANT, wide_s);
    dbits = wide_s ? eeprom_pkg::DATA_BITS_WIDE : eeprom_pkg::DATA_BITS_NARROW;
    hdr_len = eeprom_pkg::OPCODE_BITS + abits;
    amask = 11'((12'h001 << abits) - 12'h001);
    dmask = 16'((17'h00001 << dbits) - 17'h00001);
    cap_mask = 11'((12'h001 << eeprom_pkg::cap_bits(VARIANT)) - 12'h001);
    wmask = wide_s ? (cap_mask >> 1) : cap_mask;
  end

  function automatic logic [eeprom_pkg::ADDR_W-1:0] byte_base(input logic [10:0] a);
    logic [eeprom_pkg::ADDR_W-1:0] b;
    b = wide_s ? {a[9:0], 1'b0} : a;
    return b & cap_mask;
  endfunction

  function automatic logic [eeprom_pkg::DATA_W-1:0] word_at(input logic [10:0] a);
    logic [eeprom_pkg::ADDR_W-1:0] b;
    b = byte_base(a);
    return wide_s ? {mem[b], mem[{b[10:1], 1'b1}]} : {mem[b], 8'h00};
  endfunction

  // ---------------- Link domain, control state cleared whenever the chip is deselected
  eeprom_pkg::link_state_type lstate_reg, lstate_next;
  logic [eeprom_pkg::CNT_W-1:0] cnt_reg, cnt_next, rd_bits_reg, rd_bits_next;
  logic phase_reg, phase_next, out_bit_reg, out_bit_next, out_en_reg, out_en_next;
  logic rel_reg, rel_next;
  logic [eeprom_pkg::SHIFT_W-1:0] sh_reg, sh_next, hdr;
  logic [eeprom_pkg::DATA_W-1:0] rd_word_reg, rd_word_next;
  logic [eeprom_pkg::ADDR_W-1:0] rd_addr_reg, rd_addr_next, f_addr;
  logic [1:0] f_op;
  eeprom_pkg::kind_type f_kind;
  logic seq_ok, rd_start, rd_reload;

  assign seq_ok = (VARIANT != eeprom_pkg::V1K);
  assign frame_done = lstate_reg[3];

  always_comb begin
    lstate_next = lstate_reg;
    cnt_next = cnt_reg;
    phase_next = phase_reg;
    sh_next = sh_reg;
    cmd_next = cmd_reg;
    rd_word_next = rd_word_reg;
    rd_addr_next = rd_addr_reg;
    rd_bits_next = rd_bits_reg;
    out_bit_next = out_bit_reg;
    out_en_next = out_en_reg;
    hdr = '0;
    f_op = 2'h0;
    f_addr = '0;
    f_kind = eeprom_pkg::K_LOCK;
    rd_start = 1'b0;
    rd_reload = 1'b0;
    case (lstate_reg)
      eeprom_pkg::L_IDLE: begin
        // leading zeros ignored until start one
        if (serial_in) begin
          lstate_next = eeprom_pkg::L_SHIFT;
          cnt_next = '0;
          phase_next = 1'b0;
        end
      end
      eeprom_pkg::L_SHIFT: begin
        sh_next = {sh_reg[eeprom_pkg::SHIFT_W-2:0], serial_in};
        cnt_next = cnt_reg + 5'h01;
        hdr = phase_reg ? (sh_next >> dbits) : sh_next;
        f_op = hdr[abits +: 2];
        f_addr = hdr[eeprom_pkg::ADDR_W-1:0] & amask;
        f_kind = eeprom_pkg::decode_kind(f_op, 2'(f_addr >> (abits - 5'h02)));
        if (!phase_reg && cnt_next == hdr_len) begin
          if (f_kind == eeprom_pkg::K_READ) begin
            rd_start = 1'b1;
            lstate_next = eeprom_pkg::L_READ;
            rd_addr_next = f_addr;
            rd_word_next = word_at(f_addr);
            rd_bits_next = dbits;
            out_bit_next = 1'b0;
            out_en_next = 1'b1;
          end else if (f_kind == eeprom_pkg::K_WRITE || f_kind == eeprom_pkg::K_FILL_ALL) begin
            phase_next = 1'b1;
          end else begin
            cmd_next = '{f_kind, f_addr, 16'h0000};
            lstate_next = eeprom_pkg::L_DONE;
          end
        end else if (phase_reg && cnt_next == hdr_len + dbits) begin
          cmd_next = '{f_kind, f_addr, sh_next[eeprom_pkg::DATA_W-1:0] & dmask};
          lstate_next = eeprom_pkg::L_DONE;
        end
      end
      eeprom_pkg::L_READ: begin
        if (rd_bits_reg != '0) begin
          out_bit_next = rd_word_reg[eeprom_pkg::DATA_W-1];
          rd_word_next = {rd_word_reg[eeprom_pkg::DATA_W-2:0], 1'b0};
          rd_bits_next = rd_bits_reg - 5'h01;
          if (rd_bits_reg == 5'h01 && seq_ok) begin
            rd_reload = 1'b1;
            rd_addr_next = (rd_addr_reg + 11'h001) & wmask;
            rd_word_next = word_at((rd_addr_reg + 11'h001) & wmask);
            rd_bits_next = dbits;
          end
        end else begin
          out_en_next = 1'b0;
        end
      end
      default: begin
        lstate_next = eeprom_pkg::L_DONE;
      end
    endcase
  end

  always_ff @(posedge serial_clock_in or negedge chip_select) begin
    if (!chip_select) begin
      lstate_reg <= eeprom_pkg::L_IDLE;
      cnt_reg <= '0;
      phase_reg <= 1'b0;
      rd_bits_reg <= '0;
      out_bit_reg <= 1'b0;
      out_en_reg <= 1'b0;
    end else begin
      lstate_reg <= lstate_next;
      cnt_reg <= cnt_next;
      phase_reg <= phase_next;
      rd_bits_reg <= rd_bits_next;
      out_bit_reg <= out_bit_next;
      out_en_reg <= out_en_next;
    end
  end

  // Data path keeps the last command for the store side to pick up
  always_ff @(posedge serial_clock_in) begin
    sh_reg <= sh_next;
    cmd_reg <= cmd_next;
    rd_word_reg <= rd_word_next;
    rd_addr_reg <= rd_addr_next;
  end

  always_comb begin
    rel_next = rel_reg | ~lstate_reg[0];
  end

  always_ff @(negedge serial_clock_in or negedge chip_select) begin
    if (!chip_select) begin
      rel_reg <= 1'b0;
    end else begin
      rel_reg <= rel_next;
    end
  end

  // ---------------- Store domain
  logic cs_prev_reg, cs_prev_next, done_prev_reg, done_prev_next;
  logic unlocked_reg, unlocked_next, busy_reg, busy_next, armed_reg, armed_next;
  logic sweep_on_reg, sweep_on_next, pwide_reg, pwide_next;
  logic [CYC_W-1:0] cyc_reg, cyc_next;
  logic [eeprom_pkg::ADDR_W-1:0] sweep_reg, sweep_next, tgt;
  eeprom_pkg::command_type pcmd_reg, pcmd_next;
  logic launch, is_store, pe_ok, accept, mem_we, match;
  logic [7:0] mem_wdata;

  always_comb begin
    cs_prev_next = cs_s;
    done_prev_next = done_s;
    unlocked_next = unlocked_reg;
    busy_next = busy_reg;
    armed_next = armed_reg;
    sweep_on_next = sweep_on_reg;
    sweep_next = sweep_reg;
    pwide_next = pwide_reg;
    cyc_next = cyc_reg;
    pcmd_next = pcmd_reg;
    launch = cs_prev_reg & ~cs_s & done_prev_reg;
    is_store = cmd_reg.kind == eeprom_pkg::K_WRITE || cmd_reg.kind == eeprom_pkg::K_ERASE
      || cmd_reg.kind == eeprom_pkg::K_ERASE_ALL || cmd_reg.kind == eeprom_pkg::K_FILL_ALL;
    pe_ok = (VARIANT != eeprom_pkg::V16K) | pe_s;
    accept = launch & is_store & unlocked_reg & pe_ok & ~busy_reg;
    if (launch && cmd_reg.kind == eeprom_pkg::K_UNLOCK) begin
      unlocked_next = 1'b1;
    end else if (launch && cmd_reg.kind == eeprom_pkg::K_LOCK) begin
      unlocked_next = 1'b0;
    end
    if (cs_prev_reg && !cs_s && !busy_reg) begin
      armed_next = 1'b0;
    end
    if (accept) begin
      busy_next = 1'b1;
      armed_next = 1'b1;
      sweep_on_next = 1'b1;
      sweep_next = '0;
      cyc_next = '0;
      pcmd_next = cmd_reg;
      pwide_next = wide_s;
    end else if (busy_reg) begin
      cyc_next = cyc_reg + CYC_W'(1);
      if (cyc_reg == CYC_LAST) begin
        busy_next = 1'b0;
      end
      if (sweep_on_reg) begin
        sweep_next = sweep_reg + 11'h001;
        if (sweep_reg == cap_mask) begin
          sweep_on_next = 1'b0;
        end
      end
    end
  end

  always_comb begin
    tgt = (pwide_reg ? {pcmd_reg.addr[9:0], 1'b0} : pcmd_reg.addr) & cap_mask;
    if (pcmd_reg.kind == eeprom_pkg::K_ERASE_ALL || pcmd_reg.kind == eeprom_pkg::K_FILL_ALL) begin
      match = 1'b1;
    end else if (pwide_reg) begin
      match = sweep_reg[10:1] == tgt[10:1];
    end else begin
      match = sweep_reg == tgt;
    end
    mem_we = busy_reg & sweep_on_reg & match;
    if (pcmd_reg.kind == eeprom_pkg::K_ERASE || pcmd_reg.kind == eeprom_pkg::K_ERASE_ALL) begin
      mem_wdata = eeprom_pkg::ERASED_BYTE;
    end else if (pwide_reg && !sweep_reg[0]) begin
      mem_wdata = pcmd_reg.data[15:8];
    end else begin
      mem_wdata = pcmd_reg.data[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (mem_we) begin
      mem[sweep_reg] <= mem_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cs_prev_reg <= 1'b0;
      done_prev_reg <= 1'b0;
      unlocked_reg <= 1'b0;
      busy_reg <= 1'b0;
      armed_reg <= 1'b0;
      sweep_on_reg <= 1'b0;
      sweep_reg <= '0;
      pwide_reg <= 1'b1;
      cyc_reg <= '0;
      pcmd_reg <= '0;
    end else begin
      cs_prev_reg <= cs_prev_next;
      done_prev_reg <= done_prev_next;
      unlocked_reg <= unlocked_next;
      busy_reg <= busy_next;
      armed_reg <= armed_next;
      sweep_on_reg <= sweep_on_next;
      sweep_reg <= sweep_next;
      pwide_reg <= pwide_next;
      cyc_reg <= cyc_next;
      pcmd_reg <= pcmd_next;
    end
  end

  // ---------------- Pin outputs
  logic status_drive;
  assign status_drive = chip_select & armed_reg & ~rel_reg;
  assign serial_out = status_drive ? ~busy_reg : out_bit_reg;
  assign serial_out_oe_n = ~(status_drive | (out_en_reg & chip_select));
  assign busy = busy_reg;
  assign write_unlocked = unlocked_reg;

  // ---------------- Assertions
  property p_cycle_bound;
    @(posedge clk) disable iff (rst) busy_reg |-> cyc_reg <= CYC_LAST;
  endproperty
  a_cycle_bound: assert property (p_cycle_bound) else $error("cycle overran");

  property p_ready_at_end;
    @(posedge clk) disable iff (rst) $fell(busy_reg) |-> $past(cyc_reg) == CYC_LAST;
  endproperty
  a_ready_at_end: assert property (p_ready_at_end) else $error("early ready");

  property p_launch_on_deselect;
    @(posedge clk) disable iff (rst)
      $rose(busy_reg) |-> $past(cs_prev_reg) && !$past(cs_s) && $past(done_prev_reg);
  endproperty
  a_launch_on_deselect: assert property (p_launch_on_deselect) else $error("bad launch");

  property p_locked_refused;
    @(posedge clk) disable iff (rst) $rose(busy_reg) |-> $past(unlocked_reg);
  endproperty
  a_locked_refused: assert property (p_locked_refused) else $error("store while locked");

  property p_pe_gate;
    @(posedge clk) disable iff (rst)
      $rose(busy_reg) && VARIANT == eeprom_pkg::V16K |-> $past(pe_s);
  endproperty
  a_pe_gate: assert property (p_pe_gate) else $error("store without enable");

  property p_unlock_ignores_pe;
    @(posedge clk) disable iff (rst)
      launch && cmd_reg.kind == eeprom_pkg::K_UNLOCK |=> unlocked_reg;
  endproperty
  a_unlock_ignores_pe: assert property (p_unlock_ignores_pe) else $error("unlock lost");

  property p_status_value;
    @(posedge clk) disable iff (rst) status_drive |-> !serial_out_oe_n && serial_out == !busy_reg;
  endproperty
  a_status_value: assert property (p_status_value) else $error("status wrong");

  property p_hiz_deselected;
    @(posedge clk) disable iff (rst) !chip_select |-> serial_out_oe_n;
  endproperty
  a_hiz_deselected: assert property (p_hiz_deselected) else $error("driven deselected");

  property p_read_dummy;
    @(posedge serial_clock_in) disable iff (!chip_select)
      rd_start |=> out_en_reg && !out_bit_reg ##1 out_bit_reg == $past(rd_word_reg[15]);
  endproperty
  a_read_dummy: assert property (p_read_dummy) else $error("read start wrong");

  property p_frame_len;
    @(posedge serial_clock_in) disable iff (!chip_select)
      lstate_reg == eeprom_pkg::L_SHIFT && lstate_next == eeprom_pkg::L_DONE
      |-> cnt_next == hdr_len || cnt_next == hdr_len + dbits;
  endproperty
  a_frame_len: assert property (p_frame_len) else $error("frame length wrong");

  c_read: cover property (@(posedge serial_clock_in) rd_start);
  c_seq_read: cover property (@(posedge serial_clock_in) rd_reload);
  c_store: cover property (@(posedge clk) accept);
  c_ready_seen: cover property (@(posedge clk) status_drive && !busy_reg);
endmodule // serial_eeprom_command_port

// [tb/eeprom_host_model.sv]
// Host model that drives the serial command link of the EEPROM port
`timescale 1ns/1ps
module eeprom_host_model (
  input wire logic clk,
  output logic chip_select,
  output logic serial_clock_in,
  output logic serial_in,
  input wire logic serial_out,
  input wire logic serial_out_oe_n
);
  logic [63:0] rd;
  logic line;
  // Released output has no pull: model it as showing the inverse of the last bit
  assign line = serial_out_oe_n ? ~serial_out : serial_out;
  // A real high to low step so the link side clears at start-up
  initial begin
    chip_select = 1'h1;
    serial_clock_in = 1'h0;
    serial_in = 1'h0;
    rd = '0;
    #1 chip_select = 1'h0;
  end
  // top n bits sent MSB first, set while clock low
  task automatic xfer(input logic [28:0] bits, input int n, input int nr);
    @(negedge clk);
    chip_select = 1'h1;
    #20;
    rd = '0;
    for (int i = 0; i < n + nr; i++) begin
      serial_in = (i < n) ? bits[28-i] : 1'h0;
      #6 serial_clock_in = 1'h1;
      #6 serial_clock_in = 1'h0;
      rd = {rd[62:0], line};
    end
    serial_in = ~serial_in;
  endtask
  // deselect after the last edge, held low long enough
  task automatic deselect();
    #100;
    @(negedge clk);
    chip_select = 1'h0;
    repeat (5) @(negedge clk);
  endtask
  task automatic select();
    @(negedge clk);
    chip_select = 1'h1;
    repeat (3) @(negedge clk);
  endtask
  // dummy one hands the shared line back before new bits
  task automatic dummy_one(output logic oe_hi, output logic oe_lo);
    serial_in = 1'h1;
    #6 serial_clock_in = 1'h1;
    #3 oe_hi = serial_out_oe_n;
    #3 serial_clock_in = 1'h0;
    #1 oe_lo = serial_out_oe_n;
    serial_in = 1'h0;
  endtask
endmodule // eeprom_host_model

// [tb/serial_eeprom_command_port_tb_top.sv]
// Self-checking bench for the serial EEPROM command port
`timescale 1ns/1ps
module serial_eeprom_command_port_tb_top;
  localparam int PCYC = 2100;
  logic clk, rst, chip_select, serial_clock_in, serial_in, serial_out, serial_out_oe_n;
  logic word_width_select, program_enable_pin, busy, write_unlocked, hi, lo;
  logic [31:0] seed;
  logic [15:0] d1, d2, fv;
  int errors, check_count;
  serial_eeprom_command_port #(.VARIANT(eeprom_pkg::V16K), .PROG_CYCLES(PCYC)) dut_u (
    .clk(clk), .rst(rst), .chip_select(chip_select), .serial_clock_in(serial_clock_in),
    .serial_in(serial_in), .serial_out(serial_out), .serial_out_oe_n(serial_out_oe_n),
    .word_width_select(word_width_select), .program_enable_pin(program_enable_pin),
    .busy(busy), .write_unlocked(write_unlocked));
  eeprom_host_model host_u (
    .clk(clk), .chip_select(chip_select), .serial_clock_in(serial_clock_in),
    .serial_in(serial_in), .serial_out(serial_out), .serial_out_oe_n(serial_out_oe_n));
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string msg);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
  endfunction
  function automatic logic [28:0] frame(input logic [1:0] op, input logic [9:0] a,
                                        input logic [15:0] d);
    return {1'h1, op, a, d};
  endfunction
  // Accepted store: status low while running, high when done, then release
  task automatic store(input logic [28:0] f, input int n);
    int k;
    host_u.xfer(f, n, 0);
    host_u.deselect();
    host_u.select();
    check(serial_out_oe_n, 64'h0, "status drive");
    check(host_u.line, 64'h0, "status busy");
    for (k = 0; k < 3000 && host_u.line !== 1'h1; k++) @(negedge clk);
    if (host_u.line !== 1'h1) begin
      errors++;
      test_done();
    end
    check(k <= PCYC, 64'h1, "cycle length");
    host_u.dummy_one(hi, lo);
    check({hi, lo}, 64'h1, "release edge");
    host_u.deselect();
  endtask
  task automatic refused(input logic [28:0] f, input int n);
    host_u.xfer(f, n, 0);
    host_u.deselect();
    repeat (10) @(negedge clk);
    check(busy, 64'h0, "store refused");
    host_u.select();
    check(serial_out_oe_n, 64'h1, "no status");
    host_u.deselect();
  endtask
  task automatic rd_check(input logic [28:0] f, input int n, input int nr, input logic [63:0] e);
    host_u.xfer(f, n, nr);
    check(serial_out_oe_n, 64'h0, "read drive");
    check(host_u.rd & ((64'h1 << (nr + 1)) - 64'h1), e, "read data");
    host_u.deselect();
  endtask
  initial begin
    repeat (90000) @(posedge clk);
    errors++;
    test_done();
  end
  initial begin
    rst = 1'h1;
    word_width_select = 1'h1;
    program_enable_pin = 1'h0;
    errors = 0;
    check_count = 0;
    seed = 32'h00012A2A;
    repeat (12) @(negedge clk);
    rst = 1'h0;
    // host waits out the power-up delay
    repeat (10000) @(negedge clk);
    check({busy, write_unlocked, serial_out_oe_n}, 64'h1, "reset state");
    refused(frame(eeprom_pkg::OP_WRITE, 10'h3FF, 16'h1234), 29);
    host_u.xfer(frame(eeprom_pkg::OP_EXT, {eeprom_pkg::EXT_UNLOCK, 8'h00}, 16'h0), 13, 0);
    host_u.deselect();
    check(write_unlocked, 64'h1, "unlock");
    refused(frame(eeprom_pkg::OP_WRITE, 10'h3FF, 16'h1234), 29);
    program_enable_pin = 1'h1;
    $display("test lock and enable done");
    seed = lfsr(seed);
    fv = seed[15:0];
    store(frame(eeprom_pkg::OP_EXT, {eeprom_pkg::EXT_FILL, 8'h00}, fv), 29);
    rd_check(frame(eeprom_pkg::OP_READ, seed[25:16], 16'h0), 13, 32, {fv, fv});
    store(frame(eeprom_pkg::OP_EXT, {eeprom_pkg::EXT_ERASE_ALL, 8'h00}, 16'h0), 13);
    rd_check(frame(eeprom_pkg::OP_READ, 10'h3FF, 16'h0), 13, 16, 64'hFFFF);
    $display("test fill and erase all done");
    seed = lfsr(seed);
    d1 = seed[15:0];
    seed = lfsr(seed);
    d2 = seed[15:0];
    store(frame(eeprom_pkg::OP_WRITE, 10'h3FF, d1), 29);
    store(frame(eeprom_pkg::OP_WRITE, 10'h000, d2), 29);
    rd_check(frame(eeprom_pkg::OP_READ, 10'h3FF, 16'h0), 13, 32, {d1, d2});
    $display("test write and wrap done");
    host_u.xfer(frame(eeprom_pkg::OP_ERASE, 10'h000, 16'h0), 10, 0);
    host_u.deselect();
    check(busy, 64'h0, "aborted frame");
    rd_check(frame(eeprom_pkg::OP_READ, 10'h000, 16'h0), 13, 16, d2);
    store(frame(eeprom_pkg::OP_ERASE, 10'h000, 16'h0), 13);
    rd_check(frame(eeprom_pkg::OP_READ, 10'h000, 16'h0), 13, 16, 64'hFFFF);
    $display("test abort and erase done");
    word_width_select = 1'h0;
    repeat (10) @(negedge clk);
    rd_check({1'h1, eeprom_pkg::OP_READ, 11'h7FF, 15'h0}, 14, 8, d1[7:0]);
    word_width_select = 1'h1;
    repeat (10) @(negedge clk);
    $display("test byte mode done");
    host_u.xfer(frame(eeprom_pkg::OP_EXT, {eeprom_pkg::EXT_LOCK, 8'h00}, 16'h0), 13, 0);
    host_u.deselect();
    check(write_unlocked, 64'h0, "lock");
    refused(frame(eeprom_pkg::OP_WRITE, 10'h000, d1), 29);
    $display("test relock done");
    test_done();
  end
endmodule // serial_eeprom_command_port_tb_top
